// >>> verilog/ssh_pkg.sv
// Constants, register map and enumerations of the split-strobe host port
// Operation
// - Byte writes only to selects 01b,10b,11b
// - Select valid before chip select falls
// - Byte write: strobes low, data, raise both
// - Word writes only to select 00b
// - Hold select 00b throughout word write
// - Word bytes go most significant first
// - Strobe each byte; chip select stays low
// - Raise chip select after fourth byte
// - Byte reads only from select 01b
// - Hold select stable for whole read
// - Release data bus before read strobes
// - Raise both strobes after sampling byte
// - Status write: lane field 11b, reserved 0
package ssh_pkg;

    // Device-side register selects
    localparam logic [1:0] SEL_MESSAGE_WORD = 2'h0;
    localparam logic [1:0] SEL_HOST_STATUS  = 2'h1;
    localparam logic [1:0] SEL_AUDIO_IN_ONE = 2'h2;
    localparam logic [1:0] SEL_AUDIO_IN_TWO = 2'h3;

    // Device status register layout
    localparam int         STAT_IN_BUSY_BIT  = 2;
    localparam int         STAT_PENDING_BIT  = 1;
    localparam logic [7:0] STATUS_WRITE_BYTE = 8'h18;

    // Own AHB register byte offsets
    localparam logic [7:0] OFS_COMMAND  = 8'h00;
    localparam logic [7:0] OFS_WDATA    = 8'h04;
    localparam logic [7:0] OFS_RDATA    = 8'h08;
    localparam logic [7:0] OFS_STATE    = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLR  = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h18;

    // Command register fields
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_SEL_LSB = 2;

    // State register bits
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_PENDING_BIT = 1;
    localparam int ST_INBUSY_BIT  = 2;

    // Interrupt status bits
    localparam int IRQ_DONE_BIT    = 0;
    localparam int IRQ_MSG_BIT     = 1;
    localparam int IRQ_FREE_BIT    = 2;
    localparam int IRQ_REFUSED_BIT = 3;
    localparam int IRQ_W           = 4;

    // Reset values
    localparam logic [31:0]      WDATA_RESET  = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 4'h0;

    // Strobe phase timing
    localparam int CLK_MHZ   = 100;
    localparam int PHASE_NS  = 40;
    localparam int PHASE_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] PHASE_LOAD = 4'(PHASE_CYC - 1);

    // Operations
    typedef enum logic [1:0] {
        OP_BYTE_WRITE,
        OP_WORD_WRITE,
        OP_BYTE_READ,
        OP_NONE
    } ssh_op_e;

    // Pin sequencer states
    typedef enum logic [2:0] {
        S_IDLE,
        S_SETUP,
        S_ACTIVE,
        S_STROBE,
        S_CLOSE,
        S_FINISH
    } ssh_state_e;

endpackage

// >>> verilog/ssh_host_port.sv
// Host controller for the split-strobe byte-wide port, AHB-Lite slave
`timescale 1ns/10ps
module ssh_host_port (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    // Device pins
    output logic             cs_n,
    output logic             wr_n,
    output logic             rd_n,
    output logic             reg_select_hi,
    output logic             reg_select_lo,
    output logic      [7:0]  host_bus_byte_o,
    output logic             host_bus_byte_oe,
    input  wire logic [7:0]  host_bus_byte_i,
    input  wire logic        msg_irq_n,
    input  wire logic        in_word_busy
);
    import ssh_pkg::*;
    // One command write becomes a whole pin sequence. Each
    // strobe phase lasts PHASE_CYC clocks; the device has no
    // handshake, so timing is open loop and must cover the
    // slowest device access. One command runs at a time: a
    // command during a sequence is refused, never queued.
    // Pins are driven from flops only; the data pins are
    // released whenever no write is in flight.

    logic             rst_meta;      // Reset synchroniser first stage
    logic             rst_sync_n;    // Released reset copy
    logic             wr_pend;       // Write data phase pending
    logic [7:0]       wr_addr;       // Latched write offset
    logic [1:0]       cmd_op;        // Requested operation
    logic [1:0]       cmd_sel;       // Requested byte-write select
    logic             go;            // One-cycle start request
    logic [31:0]      wdata;         // Outgoing data word
    logic [7:0]       rdata;         // Last byte read from device
    logic [IRQ_W-1:0] irq_stat;      // Sticky event bits
    logic [IRQ_W-1:0] irq_en;        // Event enables
    logic [IRQ_W-1:0] irq_clr;       // Clear pulse from bus
    logic [IRQ_W-1:0] irq_set;       // Event pulses
    ssh_state_e       state;         // Pin sequencer state
    ssh_op_e          op_q;          // Operation in flight
    logic [3:0]       cnt;           // Phase counter
    logic [1:0]       lane;          // Byte lane index of a word
    logic [31:0]      shift;         // Word shifter, top lane leaves first
    logic             done;          // Operation finished pulse
    logic             refused;       // Illegal or busy command
    logic             pend_q;        // Previous pending level
    logic             inbusy_q;      // Previous device busy level
    logic             busy;          // Sequencer not idle
    logic             addr_ok;       // Valid address phase

    // Reset released through two flops; asserts at once
    // Release is clocked so no flop sees a runt recovery
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Always ready and OKAY: every register answers in its
    // data phase, so no wait state is ever inserted
    // Interrupt is a level of enabled sticky bits
    assign busy      = (state != S_IDLE);
    assign addr_ok   = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = |(irq_stat & irq_en);

    // Address phase capture for writes
    // Write data arrives a cycle later, so keep the offset
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_addr <= haddr[7:0];
            end
        end
    end

    // Read data registered at the address phase: zero wait states
    // Pending and in-busy state bits are live pin levels, not latched copies; busy is the sequencer state
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            unique case ({haddr[7:2], 2'b00})
                OFS_WDATA:    hrdata <= wdata;
                OFS_RDATA:    hrdata <= {24'h00_0000, rdata};
                OFS_STATE:    hrdata <= {29'h0000_0000, in_word_busy,
                                         !msg_irq_n, busy};
                OFS_IRQ_STAT: hrdata <= {28'h000_0000, irq_stat};
                OFS_IRQ_EN:   hrdata <= {28'h000_0000, irq_en};
                default:      hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Register writes in the data phase
    // Go lasts one cycle: the sequencer takes the command
    // at once or flags it refused
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wdata   <= WDATA_RESET;
            irq_en  <= IRQ_EN_RESET;
            irq_clr <= '0;
            cmd_op  <= 2'h0;
            cmd_sel <= 2'h0;
            go      <= 1'b0;
        end else begin
            go      <= 1'b0;
            irq_clr <= '0;
            if (wr_pend) begin
                unique case (wr_addr)
                    OFS_COMMAND: begin
                        cmd_op  <= hwdata[CMD_OP_LSB +: 2];
                        cmd_sel <= hwdata[CMD_SEL_LSB +: 2];
                        go      <= 1'b1;
                    end
                    OFS_WDATA:   wdata   <= hwdata;
                    OFS_IRQ_CLR: irq_clr <= hwdata[IRQ_W-1:0];
                    OFS_IRQ_EN:  irq_en  <= hwdata[IRQ_W-1:0];
                    default: begin
                        // Unmapped or read-only: write ignored
                    end
                endcase
            end
        end
    end

    // Refuse commands while busy or with a select the port forbids
    // A refusal costs less than a queue and keeps pins simple
    always_comb begin
        refused = 1'b0;
        if (go) begin
            if (busy) begin
                refused = 1'b1;
            end else if (cmd_op == OP_BYTE_WRITE &&
                         cmd_sel == SEL_MESSAGE_WORD) begin
                refused = 1'b1;
            end else if (cmd_op == OP_NONE) begin
                // No pin sequence exists for this code
                refused = 1'b1;
            end
        end
    end

    // Pin sequencer: select, strobes, lane order, bus drive
    // Every pin is a flop, so no strobe can glitch. Select
    // pins move only in IDLE, a phase before chip select
    // falls, and hold until the next command.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            // Pins park idle: strobes high, bus released
            state            <= S_IDLE;
            op_q             <= OP_NONE;
            cnt              <= 4'h0;
            lane             <= 2'h0;
            shift            <= 32'h0000_0000;
            cs_n             <= 1'b1;
            wr_n             <= 1'b1;
            rd_n             <= 1'b1;
            reg_select_hi    <= 1'b0;
            reg_select_lo    <= 1'b0;
            host_bus_byte_o  <= 8'h00;
            host_bus_byte_oe <= 1'b0;
            rdata            <= 8'h00;
            done             <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state)
                S_IDLE: begin
                    if (go && !refused) begin
                        op_q  <= ssh_op_e'(cmd_op);
                        cnt   <= PHASE_LOAD;
                        lane  <= 2'h0;
                        state <= S_SETUP;
                        // Select fixed before chip select falls
                        unique case (ssh_op_e'(cmd_op))
                            OP_WORD_WRITE: begin
                                {reg_select_hi, reg_select_lo}
                                    <= SEL_MESSAGE_WORD;
                                shift <= wdata;
                            end
                            OP_BYTE_READ: begin
                                {reg_select_hi, reg_select_lo}
                                    <= SEL_HOST_STATUS;
                            end
                            default: begin
                                {reg_select_hi, reg_select_lo}
                                    <= cmd_sel;
                                // Status writes carry fixed lane field
                                if (cmd_sel == SEL_HOST_STATUS) begin
                                    shift <= {STATUS_WRITE_BYTE,
                                              24'h00_0000};
                                end else begin
                                    shift <= {wdata[7:0], 24'h00_0000};
                                end
                            end
                        endcase
                        // Bus released ahead of a read
                        host_bus_byte_oe <= 1'b0;
                    end
                end
                S_SETUP: begin
                    // Select settles a phase before strobes
                    if (cnt == 4'h0) begin
                        cs_n  <= 1'b0;
                        cnt   <= PHASE_LOAD;
                        state <= S_ACTIVE;
                        if (op_q == OP_BYTE_READ) begin
                            rd_n <= 1'b0;
                        end else begin
                            wr_n             <= 1'b0;
                            host_bus_byte_o  <= shift[31:24];
                            host_bus_byte_oe <= 1'b1;
                        end
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                S_ACTIVE: begin
                    // Strobe stays low for one full phase
                    if (cnt == 4'h0) begin
                        cnt <= PHASE_LOAD;
                        unique case (op_q)
                            OP_BYTE_READ: begin
                                // Sample, then raise both strobes
                                rdata <= host_bus_byte_i;
                                rd_n  <= 1'b1;
                                cs_n  <= 1'b1;
                                state <= S_FINISH;
                            end
                            OP_WORD_WRITE: begin
                                // Rising write strobe latches the byte
                                wr_n  <= 1'b1;
                                state <= (lane == 2'h3) ? S_CLOSE
                                                        : S_STROBE;
                            end
                            default: begin
                                wr_n  <= 1'b1;
                                cs_n  <= 1'b1;
                                state <= S_FINISH;
                            end
                        endcase
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                S_STROBE: begin
                    // Chip select stays low between bytes
                    if (cnt == 4'h0) begin
                        wr_n            <= 1'b0;
                        lane            <= lane + 2'h1;
                        shift           <= {shift[23:0], 8'h00};
                        host_bus_byte_o <= shift[23:16];
                        cnt             <= PHASE_LOAD;
                        state           <= S_ACTIVE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                S_CLOSE: begin
                    // Fourth byte in: end the word transaction
                    if (cnt == 4'h0) begin
                        cs_n             <= 1'b1;
                        host_bus_byte_oe <= 1'b0;
                        cnt              <= PHASE_LOAD;
                        state            <= S_FINISH;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                S_FINISH: begin
                    // Recovery time with chip select high
                    // Byte-write data lingers a clock past the strobes
                    host_bus_byte_oe <= 1'b0;
                    if (cnt == 4'h0) begin
                        done  <= 1'b1;
                        state <= S_IDLE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: begin
                    // Illegal code: back to idle
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Edge memory of device pins, inputs are synchronous
    // Reset levels match idle pins, so no false event
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pend_q   <= 1'b0;
            inbusy_q <= 1'b0;
        end else begin
            pend_q   <= !msg_irq_n;
            inbusy_q <= in_word_busy;
        end
    end

    // Events; a low irq pin also covers unsolicited messages
    // Busy falling means the core took the word
    always_comb begin
        irq_set                  = '0;
        irq_set[IRQ_DONE_BIT]    = done;
        irq_set[IRQ_MSG_BIT]     = !msg_irq_n && !pend_q;
        irq_set[IRQ_FREE_BIT]    = !in_word_busy && inbusy_q;
        irq_set[IRQ_REFUSED_BIT] = refused;
    end

    // Sticky status; a set in the clear cycle wins
    // Clear is a registered pulse, one cycle after the write
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        end
    end

endmodule

// >>> testbench/ssh_host_port_sva.sv
// Pin-level checker for the split-strobe host port controller
`timescale 1ns/10ps
module ssh_host_port_sva (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       cs_n,
    input wire logic       wr_n,
    input wire logic       rd_n,
    input wire logic       reg_select_hi,
    input wire logic       reg_select_lo,
    input wire logic [7:0] host_bus_byte_o,
    input wire logic       host_bus_byte_oe,
    input wire logic       irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic [2:0] wr_rises; // Strobe rises inside one chip select

    // Count write strobe rises while the device is selected
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_rises <= 3'h0;
        end else if (cs_n) begin
            wr_rises <= 3'h0;
        end else if ($rose(wr_n)) begin
            wr_rises <= wr_rises + 3'h1;
        end
    end

    property p_rd_bus_free;
        !rd_n |-> !host_bus_byte_oe && $past(!host_bus_byte_oe);
    endproperty
    a_rd_bus_free: assert property (p_rd_bus_free)
        else $error("bus driven during read");
    property p_wr_drives;
        !wr_n |-> host_bus_byte_oe;
    endproperty
    a_wr_drives: assert property (p_wr_drives)
        else $error("write strobe without data");
    property p_strobe_in_cs;
        (!wr_n || !rd_n) |-> !cs_n;
    endproperty
    a_strobe_in_cs: assert property (p_strobe_in_cs)
        else $error("strobe outside chip select");
    property p_sel_stable;
        (!cs_n && $past(!cs_n)) |-> $stable({reg_select_hi, reg_select_lo});
    endproperty
    a_sel_stable: assert property (p_sel_stable)
        else $error("select moved while selected");
    property p_sel_setup;
        $fell(cs_n) |-> $stable({reg_select_hi, reg_select_lo});
    endproperty
    a_sel_setup: assert property (p_sel_setup)
        else $error("select changed at chip select fall");
    property p_read_sel;
        !rd_n |-> {reg_select_hi, reg_select_lo} == 2'h1;
    endproperty
    a_read_sel: assert property (p_read_sel)
        else $error("read of a register other than status");
    property p_data_hold;
        (!wr_n && $past(!wr_n)) |-> $stable(host_bus_byte_o);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("data moved under write strobe");
    property p_wr_phase;
        $fell(wr_n) |-> !wr_n [*4];
    endproperty
    a_wr_phase: assert property (p_wr_phase)
        else $error("write strobe phase too short");
    property p_rd_phase;
        $fell(rd_n) |-> !rd_n [*4] ##[1:4] (rd_n && cs_n);
    endproperty
    a_rd_phase: assert property (p_rd_phase)
        else $error("read not closed by both strobes");
    property p_word_four;
        ($rose(cs_n) && $past(!reg_select_hi && !reg_select_lo))
            |-> wr_rises == 3'h4;
    endproperty
    a_word_four: assert property (p_word_four)
        else $error("word write closed without four bytes");

    c_read: cover property ($fell(rd_n));
    c_word: cover property ($rose(cs_n) && wr_rises == 3'h4);
    c_irq:  cover property ($rose(irq));
endmodule

bind ssh_host_port ssh_host_port_sva u_sva (
    .mclk             (mclk),
    .rst_n            (rst_n),
    .cs_n             (cs_n),
    .wr_n             (wr_n),
    .rd_n             (rd_n),
    .reg_select_hi    (reg_select_hi),
    .reg_select_lo    (reg_select_lo),
    .host_bus_byte_o  (host_bus_byte_o),
    .host_bus_byte_oe (host_bus_byte_oe),
    .irq              (irq)
);

// >>> testbench/ssh_dev_model.sv
// Behavioural model of the post-processor core's host port registers
`timescale 1ns/10ps
module ssh_dev_model (
    input  wire logic        mclk,
    input  wire logic        cs_n,
    input  wire logic        wr_n,
    input  wire logic        rd_n,
    input  wire logic        sel_hi,
    input  wire logic        sel_lo,
    input  wire logic [7:0]  bus_o,
    input  wire logic        bus_oe,
    input  wire logic        post,
    input  wire logic        consume,
    output logic      [7:0]  bus_i,
    output logic             msg_irq_n,
    output logic             in_word_busy,
    output logic      [31:0] message_word,
    output logic      [7:0]  status_byte,
    output logic      [7:0]  audio_in_one,
    output logic      [7:0]  audio_in_two,
    output logic      [7:0]  cs_falls
);
    logic [1:0] sel_q   = 2'h0; // Select latched at chip select fall
    logic [1:0] lane    = 2'h0; // Next message lane, 0 is the top lane
    logic       pending = 1'b0; // Outgoing message held for the host
    logic [7:0] last    = 8'h00; // Last level seen on the data pins
    logic       drv;             // Device drives the data pins
    logic       in_cyc  = 1'b0; // Selected; cleared after a joint rise

    initial begin
        in_word_busy = 1'b0;
        message_word = 32'h0;
        cs_falls     = 8'h00;
    end

    // Bus level; released pins show a changing pattern, not a held value
    assign drv       = !cs_n && !rd_n;
    assign bus_i     = bus_oe ? bus_o :
                       drv ? {5'h00, in_word_busy, pending, 1'b0} : ~last;
    assign msg_irq_n = !pending;

    always @(posedge mclk) begin
        last <= bus_i;
    end

    // Select captured on chip select fall
    always @(negedge cs_n) begin
        sel_q    = {sel_hi, sel_lo};
        in_cyc   = 1'b1;
        cs_falls = cs_falls + 8'h01;
    end

    // Every transaction restarts at the top lane
    always @(posedge cs_n) begin
        lane = 2'h0;
        in_cyc <= 1'b0; // Late, so a joint strobe rise still counts
    end

    // Bytes taken on write strobe rise
    always @(posedge wr_n) begin
        if (in_cyc) begin
            case (sel_q)
                2'h0: begin
                    message_word[8*(3-lane) +: 8] = bus_i;
                    if (lane == 2'h3) begin
                        in_word_busy = 1'b1;
                    end
                    lane = lane + 2'h1;
                end
                2'h1:    status_byte  = bus_i;
                2'h2:    audio_in_one = bus_i;
                default: audio_in_two = bus_i;
            endcase
        end
    end

    // Core side: posting a message and consuming the word
    always @(posedge post) begin
        pending = 1'b1;
    end
    always @(posedge consume) begin
        in_word_busy = 1'b0;
    end
endmodule

// >>> testbench/ssh_host_port_tb.sv
// Self-checking testbench of the split-strobe host port controller
`timescale 1ns/10ps
module ssh_host_port_tb;
    import ssh_pkg::*;
    logic        mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, mw;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, irq, cs_n, wr_n, rd_n, shi, slo, boe;
    logic [7:0]  bo, bi, sb, a1, a2, csf;
    logic        irqn, busy, post = 1'b0, consume = 1'b0;
    int          num_errors = 0, num_checks = 0;

    always #5 mclk = ~mclk;

    ssh_host_port dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .cs_n(cs_n),
        .wr_n(wr_n), .rd_n(rd_n), .reg_select_hi(shi), .reg_select_lo(slo),
        .host_bus_byte_o(bo), .host_bus_byte_oe(boe), .host_bus_byte_i(bi),
        .msg_irq_n(irqn), .in_word_busy(busy));
    ssh_dev_model dev (.mclk(mclk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .sel_hi(shi), .sel_lo(slo), .bus_o(bo), .bus_oe(boe), .post(post),
        .consume(consume), .bus_i(bi), .msg_irq_n(irqn),
        .in_word_busy(busy), .message_word(mw), .status_byte(sb),
        .audio_in_one(a1), .audio_in_two(a2), .cs_falls(csf));

    task automatic tally_and_finish;
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One AHB single transfer; waits on hready in both phases
    task automatic ahb(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(a, 1'b1, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        ahb(a, 1'b0, 32'h0, r);
    endtask
    // Poll for completion, check the interrupt line, then clear
    task automatic wait_done(input logic exp_irq);
        logic [31:0] r;
        for (int i = 0; i < 100; i++) begin
            rd(OFS_IRQ_STAT, r);
            if (r[IRQ_DONE_BIT] === 1'b1) break;
        end
        chk(r[IRQ_DONE_BIT], 1'b1);
        chk(irq, exp_irq);
        wr(OFS_IRQ_CLR, 32'h1);
    endtask

    task automatic t_regs;
        logic [31:0] r;
        rd(OFS_IRQ_EN, r);
        chk(r, {28'h0, IRQ_EN_RESET});
        rd(8'h40, r);
        chk(r, 32'h0);
        chk({hreadyout, hresp}, 2'b10);
        wr(OFS_IRQ_EN, 32'hF);
        rd(OFS_IRQ_EN, r);
        chk(r, 32'hF);
    endtask
    task automatic t_word(input logic [31:0] w);
        logic [31:0] r;
        wr(OFS_WDATA, w);
        wr(OFS_COMMAND, 32'h1);
        wait_done(1'b1);
        chk(mw, w);
        rd(OFS_STATE, r);
        chk(r[ST_INBUSY_BIT], 1'b1);
        consume <= 1'b1;
        repeat (4) @(posedge mclk);
        consume <= 1'b0;
        rd(OFS_IRQ_STAT, r);
        chk(r[IRQ_FREE_BIT], 1'b1);
        rd(OFS_STATE, r);
        chk(r[ST_INBUSY_BIT], 1'b0);
        wr(OFS_IRQ_CLR, 32'h4);
    endtask
    task automatic t_bytes;
        for (int s = 1; s < 4; s++) begin
            wr(OFS_WDATA, 32'h50 + s);
            wr(OFS_COMMAND, s << CMD_SEL_LSB);
            wait_done(1'b1);
        end
        chk(sb, STATUS_WRITE_BYTE);
        chk(a1, 8'h52);
        chk(a2, 8'h53);
    endtask
    task automatic t_refuse;
        logic [31:0] r;
        logic [7:0]  n;
        n = csf;
        wr(OFS_COMMAND, 32'h3);
        wr(OFS_COMMAND, 32'h0);
        repeat (20) @(posedge mclk);
        rd(OFS_IRQ_STAT, r);
        chk(r[IRQ_REFUSED_BIT], 1'b1);
        chk(csf, n);
        wr(OFS_IRQ_CLR, 32'hF);
    endtask
    task automatic t_read;
        logic [31:0] r;
        post <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(OFS_STATE, r);
        chk(r[ST_PENDING_BIT], 1'b1);
        rd(OFS_IRQ_STAT, r);
        chk(r[IRQ_MSG_BIT], 1'b1);
        chk(irq, 1'b1);
        wr(OFS_IRQ_CLR, 32'hF);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        wr(OFS_IRQ_EN, 32'h0);
        wr(OFS_COMMAND, 32'h2);
        wait_done(1'b0);
        rd(OFS_RDATA, r);
        chk(r[7:0], 8'h02);
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_regs();
        t_word(32'hA1B2C3D4);
        t_word(32'h01020304);
        t_bytes();
        t_refuse();
        t_read();
        tally_and_finish();
    end
endmodule
